// *** core/dpss_pkg.sv ***
package dpss_pkg;

	// ----------------------------------------------------------------
	// widths and timing
	// ----------------------------------------------------------------
	localparam int IO_W = 32;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int CLK_PERIOD_NS = 8;
	localparam int WD_TICK_NS = 1000;
	localparam int WD_TICK_CYC = (WD_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_CNT_W = 8;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_WD_LIMIT = 4'h1;
	localparam logic [ADDR_W-1:0] REG_GROUP = 4'h2;
	localparam logic [ADDR_W-1:0] REG_IDENT = 4'h3;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STORED = 4'h5;
	localparam logic [ADDR_W-1:0] REG_PHYS = 4'h6;
	localparam logic [ADDR_W-1:0] REG_IN_IMG = 4'h7;
	localparam logic [ADDR_W-1:0] REG_DIAG_STN = 4'h8;
	localparam logic [ADDR_W-1:0] REG_DIAG_MOD = 4'h9;
	localparam logic [ADDR_W-1:0] REG_DIAG_CHN = 4'hA;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EXT_DIAG = 0;
	localparam int CTRL_WD_EN = 1;
	localparam int ST_SYNC = 0;
	localparam int ST_FREEZE = 1;
	localparam int ST_FAILSAFE = 2;
	localparam int ST_PRM_ERR = 3;
	localparam int ST_DATA_EX = 4;
	localparam int ST_DIAG_PEND = 5;
	localparam int ST_MASTER_LSB = 8;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] CTRL_RST = 2'h2;
	localparam logic [15:0] WD_LIMIT_RST = 16'h0064;
	localparam logic [7:0] GROUP_RST = 8'h00;
	// arbitrary neutral value, names no real part
	localparam logic [15:0] IDENT_DEFAULT = 16'h5A5A;

	typedef enum logic [1:0] {
		DPSS_WAIT_PRM,
		DPSS_DATA_EX
	} dpss_state_t;

	typedef struct packed {
		logic sync_cmd;
		logic unsync_cmd;
		logic freeze_cmd;
		logic unfreeze_cmd;
	} dpss_gc_cmd_t;

	// one decoded telegram from the link framer, valid for one cycle
	typedef struct packed {
		logic dx_valid;
		logic [6:0] dx_src;
		logic [IO_W-1:0] dx_data;
		logic gc_valid;
		logic [7:0] gc_group;
		dpss_gc_cmd_t gc_cmd;
		logic prm_valid;
		logic [6:0] prm_src;
		logic [15:0] prm_ident;
		logic prm_cfg_ok;
		logic prm_ext_diag;
	} dpss_link_req_t;

	typedef struct packed {
		logic valid;
		logic wr_accepted;
		logic diag_flag;
		logic [IO_W-1:0] in_data;
	} dpss_link_rsp_t;

	typedef struct packed {
		logic [7:0] station;
		logic [7:0] io_mod;
		logic [15:0] channel;
	} dpss_diag_t;

endpackage

// *** core/dpss_core.sv ***
// Functional notes
// RQ1: sync command enters Sync mode, physical outputs held at present values.
// RQ2: in Sync mode, received output data stored, physical outputs unchanged.
// RQ3: further sync command copies latest stored outputs to physical outputs.
// RQ4: unsync ends Sync mode; received outputs drive pins directly again.
// RQ5: freeze command enters Freeze mode and latches live inputs into image.
// RQ6: in Freeze mode input image refreshes only on another freeze command.
// RQ7: unfreeze ends Freeze mode; image tracks live inputs again.
// RQ8: master sends control commands to one slave, a group, or all; the core has no slave address and decodes only group_mask, or group 00 as all.
// RQ9: master multicasts its own status cyclically at configurable interval.
// RQ10: master with auto-clear forces safe outputs and Clear on slave loss.
// RQ11: master without auto-clear stays in Operate, user decides reaction.
// RQ12: master in Clear reads inputs, keeps slave outputs safe.
// RQ13: master in Stop exchanges no data with slaves.
// RQ14: master in Operate cycles inputs and outputs in fixed sequence.
// RQ15: master runs a per-slave data control timer and flags missed transfers.
// RQ16: master admits slave only when type, format, lengths and counts match.
// RQ17: slave forces safe outputs itself when exchange stops past watchdog interval.
// RQ18: only authorised master writes outputs; any master reads the images.
// RQ19: slave exposes ident number; transfer starts only on matching ident.
// RQ20: diagnostics reported at station, module and channel level.
// RQ21: extended diagnostics off by default, on only when configuration asks; the core also sets it from a REG_CTRL write of CTRL_EXT_DIAG.
// RQ22: master may resend parameters to a slave on user request.
// RQ23: sync and freeze commands travel in the global control broadcast.
// RQ24: bad parameters flagged in diagnostics; slave stays in or returns to wait-prm.
// RQ25: watchdog restarts on valid exchange; safe outputs zero until exchange resumes.
`timescale 1ns/1ps
`default_nettype none

module dpss_core
	import dpss_pkg::*;
#(
	parameter logic [15:0] IDENT_NUMBER = IDENT_DEFAULT
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire dpss_link_req_t link_req_i,
	output dpss_link_rsp_t link_rsp_o,
	input wire logic [IO_W-1:0] live_in_i,
	output logic [IO_W-1:0] phys_out_o,
	output dpss_diag_t diag_o,
	output logic [ADDR_W-1:0] unused_o,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dpss_state_t state;
	logic sync_mode;
	logic freeze_mode;
	logic failsafe;
	logic prm_err;
	logic ext_diag_en;
	logic wd_en;
	logic [6:0] auth_master;
	logic [15:0] wd_limit;
	logic [15:0] wd_cnt;
	logic [TICK_CNT_W-1:0] tick_cnt;
	logic [7:0] group_mask;
	logic [IO_W-1:0] stored;
	logic [IO_W-1:0] in_image;
	logic [7:0] diag_stn;
	logic [7:0] diag_mod;
	logic [15:0] diag_chn;

	assign unused_o = '0;

	// ----------------------------------------------------------------
	// telegram decode
	// ----------------------------------------------------------------
	wire group_hit = (link_req_i.gc_group == 8'h00) || (|(link_req_i.gc_group & group_mask)); // see RQ8
	wire gc_hit = link_req_i.gc_valid && group_hit; // see RQ23
	wire do_sync = gc_hit && link_req_i.gc_cmd.sync_cmd;
	wire do_unsync = gc_hit && link_req_i.gc_cmd.unsync_cmd && !link_req_i.gc_cmd.sync_cmd;
	wire do_freeze = gc_hit && link_req_i.gc_cmd.freeze_cmd;
	wire do_unfreeze = gc_hit && link_req_i.gc_cmd.unfreeze_cmd && !link_req_i.gc_cmd.freeze_cmd;
	// foreign masters never write; they still get a read answer
	wire dx_auth = link_req_i.dx_valid && (state == DPSS_DATA_EX) && (link_req_i.dx_src == auth_master); // see RQ18
	wire prm_good = link_req_i.prm_valid && (link_req_i.prm_ident == IDENT_NUMBER) && link_req_i.prm_cfg_ok; // see RQ19
	wire prm_bad = link_req_i.prm_valid && !prm_good;

	// ----------------------------------------------------------------
	// communication watchdog
	// ----------------------------------------------------------------
	wire tick = (tick_cnt == TICK_CNT_W'(WD_TICK_CYC - 1));
	wire wd_run = wd_en && (state == DPSS_DATA_EX) && !failsafe;
	// limit of zero would trip instantly, so it is treated as off
	wire wd_expire = wd_run && (wd_limit != 16'h0000) && (wd_cnt >= wd_limit) && !dx_auth; // see RQ17

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tick_cnt <= '0;
			wd_cnt <= '0;
		end else begin
			tick_cnt <= (tick || dx_auth) ? '0 : tick_cnt + 1'b1;
			if (dx_auth || !wd_run) begin
				wd_cnt <= '0; // see RQ25
			end else if (tick && (wd_cnt != 16'hFFFF)) begin
				wd_cnt <= wd_cnt + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// output image
	// ----------------------------------------------------------------
	wire [IO_W-1:0] next_stored = dx_auth ? link_req_i.dx_data : stored; // see RQ2
	wire [IO_W-1:0] next_phys =
		(wd_expire || (failsafe && !dx_auth)) ? '0 : // see RQ25
		(do_sync && sync_mode) ? stored : // see RQ3
		(dx_auth && !sync_mode && !do_sync) ? link_req_i.dx_data : // see RQ4
		phys_out_o; // see RQ1
	wire next_sync = do_sync ? 1'b1 : (do_unsync ? 1'b0 : sync_mode); // see RQ1

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stored <= '0;
			phys_out_o <= '0;
			sync_mode <= 1'b0;
			failsafe <= 1'b0;
		end else begin
			stored <= next_stored;
			phys_out_o <= next_phys;
			sync_mode <= next_sync;
			failsafe <= wd_expire || (failsafe && !dx_auth); // see RQ17
		end
	end

	// ----------------------------------------------------------------
	// input image
	// ----------------------------------------------------------------
	wire img_load = do_freeze || (!freeze_mode && !do_freeze); // see RQ6
	wire next_freeze = do_freeze ? 1'b1 : (do_unfreeze ? 1'b0 : freeze_mode); // see RQ7

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			in_image <= '0;
			freeze_mode <= 1'b0;
		end else begin
			in_image <= img_load ? live_in_i : in_image; // see RQ5
			freeze_mode <= next_freeze;
		end
	end

	// ----------------------------------------------------------------
	// parameterisation and link answer
	// ----------------------------------------------------------------
	wire diag_pend = (|diag_stn) || (ext_diag_en && ((|diag_mod) || (|diag_chn)));
	wire sw_clr_prm = reg_wr_i && (reg_addr_i == REG_STATUS) && reg_wdata_i[ST_PRM_ERR];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= DPSS_WAIT_PRM;
			auth_master <= '0;
			prm_err <= 1'b0;
			link_rsp_o <= '0;
		end else begin
			if (prm_good) begin
				state <= DPSS_DATA_EX;
				auth_master <= link_req_i.prm_src;
			end else if (prm_bad) begin
				state <= DPSS_WAIT_PRM; // see RQ24
			end
			// a fault in the same cycle as a clear is kept
			prm_err <= prm_bad || (prm_err && !prm_good && !sw_clr_prm); // see RQ24
			link_rsp_o.valid <= link_req_i.dx_valid;
			link_rsp_o.wr_accepted <= dx_auth;
			link_rsp_o.diag_flag <= diag_pend || prm_err;
			link_rsp_o.in_data <= in_image; // see RQ18
		end
	end

	// ----------------------------------------------------------------
	// diagnostics
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			diag_o <= '0;
		end else begin
			diag_o.station <= diag_stn; // see RQ20
			diag_o.io_mod <= ext_diag_en ? diag_mod : 8'h00; // see RQ21
			diag_o.channel <= ext_diag_en ? diag_chn : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	wire wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ext_diag_en <= CTRL_RST[CTRL_EXT_DIAG]; // see RQ21
			wd_en <= CTRL_RST[CTRL_WD_EN];
			wd_limit <= WD_LIMIT_RST;
			group_mask <= GROUP_RST;
			diag_stn <= '0;
			diag_mod <= '0;
			diag_chn <= '0;
		end else begin
			if (prm_good) begin
				ext_diag_en <= link_req_i.prm_ext_diag; // see RQ21
			end else if (wr_ctrl) begin
				ext_diag_en <= reg_wdata_i[CTRL_EXT_DIAG];
			end
			if (wr_ctrl) begin
				wd_en <= reg_wdata_i[CTRL_WD_EN];
			end
			if (reg_wr_i && (reg_addr_i == REG_WD_LIMIT)) begin
				wd_limit <= reg_wdata_i[15:0];
			end
			if (reg_wr_i && (reg_addr_i == REG_GROUP)) begin
				group_mask <= reg_wdata_i[7:0];
			end
			if (reg_wr_i && (reg_addr_i == REG_DIAG_STN)) begin
				diag_stn <= reg_wdata_i[7:0];
			end
			if (reg_wr_i && (reg_addr_i == REG_DIAG_MOD)) begin
				diag_mod <= reg_wdata_i[7:0];
			end
			if (reg_wr_i && (reg_addr_i == REG_DIAG_CHN)) begin
				diag_chn <= reg_wdata_i[15:0];
			end
		end
	end

	wire [DATA_W-1:0] status_word = {16'h0000, 1'b0, auth_master, 2'b00, diag_pend,
		(state == DPSS_DATA_EX), prm_err, failsafe, freeze_mode, sync_mode};

	function automatic logic [DATA_W-1:0] reg_read(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] r;
		r = '0;
		unique case (a)
			REG_CTRL: r = {30'h0, wd_en, ext_diag_en};
			REG_WD_LIMIT: r = {16'h0000, wd_limit};
			REG_GROUP: r = {24'h000000, group_mask};
			REG_IDENT: r = {16'h0000, IDENT_NUMBER}; // see RQ19
			REG_STATUS: r = status_word;
			REG_STORED: r = stored;
			REG_PHYS: r = phys_out_o;
			REG_IN_IMG: r = in_image;
			REG_DIAG_STN: r = {24'h000000, diag_stn};
			REG_DIAG_MOD: r = {24'h000000, diag_mod};
			REG_DIAG_CHN: r = {16'h0000, diag_chn};
			default: r = '0;
		endcase
		return r;
	endfunction

	logic [DATA_W-1:0] rd_mux;
	// a continuous assign would wake on the address only, not on the registers read
	always_comb begin
		rd_mux = reg_read(reg_addr_i);
	end

	// read data live only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : '0;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_unfreeze;
		do_unfreeze && !do_freeze ##1 !do_freeze;
	endsequence

	sequence s_sync_twice;
		do_sync && !sync_mode && !wd_expire && !failsafe ##1 !do_sync[*2];
	endsequence

	property p_sync_hold;
		sync_mode && !do_sync && !wd_expire |=> $stable(phys_out_o);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("outputs moved in sync mode"); // see RQ2

	property p_sync_enter;
		s_sync_twice |-> sync_mode && $stable(phys_out_o);
	endproperty
	a_sync_enter: assert property (p_sync_enter) else $error("sync entry did not hold outputs"); // see RQ1

	property p_sync_apply;
		sync_mode && do_sync && !wd_expire && !failsafe |=> phys_out_o == $past(stored);
	endproperty
	a_sync_apply: assert property (p_sync_apply) else $error("sync did not apply stored data"); // see RQ3

	property p_direct;
		!sync_mode && dx_auth && !gc_hit |=> phys_out_o == $past(link_req_i.dx_data);
	endproperty
	a_direct: assert property (p_direct) else $error("unsynced data not driven"); // see RQ4

	property p_freeze_latch;
		do_freeze |=> in_image == $past(live_in_i) && freeze_mode;
	endproperty
	a_freeze_latch: assert property (p_freeze_latch) else $error("freeze did not latch inputs"); // see RQ5

	property p_freeze_hold;
		freeze_mode && !do_freeze |=> $stable(in_image);
	endproperty
	a_freeze_hold: assert property (p_freeze_hold) else $error("frozen image changed"); // see RQ6

	property p_unfreeze;
		s_unfreeze |=> in_image == $past(live_in_i);
	endproperty
	a_unfreeze: assert property (p_unfreeze) else $error("image not tracking after unfreeze"); // see RQ7

	property p_wd_safe;
		wd_expire |=> failsafe && (phys_out_o == '0) ##1 ($past(dx_auth) || (phys_out_o == '0));
	endproperty
	a_wd_safe: assert property (p_wd_safe) else $error("watchdog expiry left outputs live"); // see RQ17

	property p_failsafe_hold;
		failsafe && !dx_auth |=> phys_out_o == '0 && failsafe;
	endproperty
	a_failsafe_hold: assert property (p_failsafe_hold) else $error("safe outputs released early"); // see RQ25

	property p_foreign;
		link_req_i.dx_valid && !dx_auth |=> $stable(stored) && link_rsp_o.valid && !link_rsp_o.wr_accepted;
	endproperty
	a_foreign: assert property (p_foreign) else $error("foreign master wrote outputs"); // see RQ18

	property p_prm_bad;
		prm_bad |=> state == DPSS_WAIT_PRM && prm_err;
	endproperty
	a_prm_bad: assert property (p_prm_bad) else $error("bad parameters not flagged"); // see RQ24

	property p_diag_gate;
		!ext_diag_en |=> diag_o.io_mod == 8'h00 && diag_o.channel == 16'h0000;
	endproperty
	a_diag_gate: assert property (p_diag_gate) else $error("extended diagnostics leaked"); // see RQ21

	property p_station;
		1'b1 |=> diag_o.station == $past(diag_stn);
	endproperty
	a_station: assert property (p_station) else $error("station diagnosis not reported"); // see RQ20

	property p_ident;
		link_req_i.prm_valid && link_req_i.prm_ident != IDENT_NUMBER |=> state == DPSS_WAIT_PRM;
	endproperty
	a_ident: assert property (p_ident) else $error("wrong ident admitted"); // see RQ19

endmodule

`default_nettype wire

// *** tb/dpss_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module dpss_master_model
	import dpss_pkg::*;
(
	input wire logic clk_i,
	input wire dpss_link_rsp_t link_rsp_i,
	output var dpss_link_req_t link_req_o
);
	typedef enum logic [1:0] {DPSS_M_STOP, DPSS_M_CLEAR, DPSS_M_OPERATE} dpss_m_state_t;
	dpss_m_state_t mode = DPSS_M_OPERATE;
	logic auto_clear = 1'b1;
	logic dct_err = 1'b0;
	logic [IO_W-1:0] last_in = '0;

	initial link_req_o = '0;

	// ----------------------------------------------------------------
	// telegram launch
	// ----------------------------------------------------------------
	// held one edge only; framer pulses never linger
	task automatic send(input dpss_link_req_t r);
		@(posedge clk_i);
		link_req_o <= r;
		@(posedge clk_i);
		link_req_o <= '0;
		#1;
	endtask

	task automatic gc(input logic [7:0] grp, input dpss_gc_cmd_t cmd);
		dpss_link_req_t r;
		r = '0;
		r.gc_valid = 1'b1;
		r.gc_group = grp;
		r.gc_cmd = cmd;
		send(r);
	endtask

	// status multicast carries no mode command; slaves must not react to it
	task automatic status_bcast(input int n);
		for (int i = 0; i < n; i++) begin
			gc(8'h00, '0);
		end
	endtask

	task automatic prm(input logic [6:0] src, input logic [15:0] id, input logic ok, input logic ext);
		dpss_link_req_t r;
		r = '0;
		r.prm_valid = 1'b1;
		r.prm_src = src;
		r.prm_ident = id;
		r.prm_cfg_ok = ok;
		r.prm_ext_diag = ext;
		send(r);
	endtask

	task automatic dx(input logic [6:0] src, input logic [IO_W-1:0] d);
		dpss_link_req_t r;
		r = '0;
		r.dx_valid = 1'b1;
		r.dx_src = src;
		r.dx_data = (mode == DPSS_M_CLEAR) ? '0 : d;
		if (mode != DPSS_M_STOP) begin
			send(r);
			last_in = link_rsp_i.in_data;
			if (!link_rsp_i.valid) begin
				dct_err = 1'b1;
				if (auto_clear) begin
					mode = DPSS_M_CLEAR;
				end
			end
		end
	endtask
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_top
	import dpss_pkg::*;
;
	localparam dpss_gc_cmd_t GC_SYNC = 4'h8;
	localparam dpss_gc_cmd_t GC_UNSYNC = 4'h4;
	localparam dpss_gc_cmd_t GC_FREEZE = 4'h2;
	localparam dpss_gc_cmd_t GC_UNFREEZE = 4'h1;
	logic clk_i;
	logic rst_n_i;
	dpss_link_req_t link_req;
	dpss_link_rsp_t link_rsp;
	logic [IO_W-1:0] live_in;
	logic [IO_W-1:0] phys_out;
	dpss_diag_t diag;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic [DATA_W-1:0] reg_rdata;
	logic reg_wr;
	logic reg_rd;
	int errors = 0;
	int check_count = 0;

	dpss_core dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_req_i(link_req), .link_rsp_o(link_rsp),
		.live_in_i(live_in), .phys_out_o(phys_out), .diag_o(diag), .unused_o(), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
	dpss_master_model m (.clk_i(clk_i), .link_rsp_i(link_rsp), .link_req_o(link_req));

	initial begin
		clk_i = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;
	end

	// ----------------------------------------------------------------
	// access and compare tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_i);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_i);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		logic [DATA_W-1:0] v;
		rd(a, v);
		chk(what, exp, v);
	endtask

	task automatic schk(input string what, input int pos, input logic exp);
		logic [DATA_W-1:0] v;
		rd(REG_STATUS, v);
		chk(what, 32'(exp), 32'(v[pos]));
	endtask

	task automatic dxchk(input logic [6:0] src, input logic [IO_W-1:0] d, input logic acc);
		m.dx(src, d);
		chk("rsp valid", 32'h1, 32'(link_rsp.valid));
		chk("write accepted", 32'(acc), 32'(link_rsp.wr_accepted));
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// watchdog, sized well past the whole sequence
	// ----------------------------------------------------------------
	initial begin
		#(CLK_PERIOD_NS * 5000);
		errors++;
		wrap_up;
	end

	// ----------------------------------------------------------------
	// test sequence
	// ----------------------------------------------------------------
	initial begin
		logic [DATA_W-1:0] v;
		rst_n_i = 1'b0;
		live_in = 32'hA5A5_0001;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// module and channel levels loaded, but hidden while extended diagnosis is off
		wr(REG_DIAG_MOD, 32'h22);
		wr(REG_DIAG_CHN, 32'h3344);
		rchk("ctrl", REG_CTRL, 32'(CTRL_RST));
		rchk("wd limit", REG_WD_LIMIT, 32'(WD_LIMIT_RST));
		chk("diag module", 32'h0, 32'(diag.io_mod));
		chk("diag channel", 32'h0, 32'(diag.channel));
		wr(REG_IDENT, 32'hFFFF_FFFF);
		rchk("ident", REG_IDENT, 32'(IDENT_DEFAULT));
		wr(4'hB, 32'h1);
		rchk("unmapped", 4'hB, 32'h0);
		m.prm(7'h05, ~IDENT_DEFAULT, 1'b1, 1'b0);
		schk("prm err ident", ST_PRM_ERR, 1'b1);
		dxchk(7'h05, 32'h1111_1111, 1'b0);
		chk("diag flag prm", 32'h1, 32'(link_rsp.diag_flag));
		wr(REG_STATUS, 32'h8);
		schk("prm err cleared", ST_PRM_ERR, 1'b0);
		m.prm(7'h05, IDENT_DEFAULT, 1'b0, 1'b0);
		schk("prm err cfg", ST_PRM_ERR, 1'b1);
		m.prm(7'h05, IDENT_DEFAULT, 1'b1, 1'b1);
		rd(REG_STATUS, v);
		chk("data exchange", 32'h1, 32'(v[ST_DATA_EX]));
		chk("master", 32'h5, 32'(v[ST_MASTER_LSB +: 7]));
		rchk("ctrl ext", REG_CTRL, 32'h3);
		wr(REG_DIAG_STN, 32'h11);
		rchk("diag chn reg", REG_DIAG_CHN, 32'h3344);
		chk("diag station", 32'h11, 32'(diag.station));
		chk("diag module on", 32'h22, 32'(diag.io_mod));
		chk("diag channel on", 32'h3344, 32'(diag.channel));
		// direct drive, then a foreign master is read-only
		dxchk(7'h05, 32'hD1D1_0001, 1'b1);
		chk("diag flag", 32'h1, 32'(link_rsp.diag_flag));
		rchk("phys direct", REG_PHYS, 32'hD1D1_0001);
		wr(REG_CTRL, 32'h2);
		wr(REG_DIAG_STN, 32'h0);
		chk("diag module off", 32'h0, 32'(diag.io_mod));
		dxchk(7'h09, 32'hBAD0_0009, 1'b0);
		chk("diag flag clear", 32'h0, 32'(link_rsp.diag_flag));
		chk("image to other", 32'hA5A5_0001, link_rsp.in_data);
		rchk("phys kept", REG_PHYS, 32'hD1D1_0001);
		m.gc(8'h00, GC_SYNC);
		schk("sync on", ST_SYNC, 1'b1);
		m.status_bcast(2);
		schk("sync kept", ST_SYNC, 1'b1);
		dxchk(7'h05, 32'hD2D2_0002, 1'b1);
		rchk("phys held", REG_PHYS, 32'hD1D1_0001);
		rchk("stored", REG_STORED, 32'hD2D2_0002);
		m.gc(8'h00, GC_SYNC);
		rchk("phys synced", REG_PHYS, 32'hD2D2_0002);
		m.gc(8'h00, GC_UNSYNC);
		schk("sync off", ST_SYNC, 1'b0);
		dxchk(7'h05, 32'hD3D3_0003, 1'b1);
		rchk("phys after unsync", REG_PHYS, 32'hD3D3_0003);
		// group filter, then freeze
		wr(REG_GROUP, 32'h4);
		m.gc(8'h02, GC_FREEZE);
		schk("freeze other group", ST_FREEZE, 1'b0);
		m.gc(8'h04, GC_FREEZE);
		schk("freeze on", ST_FREEZE, 1'b1);
		@(posedge clk_i);
		live_in <= 32'h5A5A_0002;
		rchk("image frozen", REG_IN_IMG, 32'hA5A5_0001);
		dxchk(7'h05, 32'hD3D3_0003, 1'b1);
		chk("reported frozen", 32'hA5A5_0001, link_rsp.in_data);
		m.gc(8'h04, GC_FREEZE);
		rchk("image refreshed", REG_IN_IMG, 32'h5A5A_0002);
		m.gc(8'h04, GC_UNFREEZE);
		@(posedge clk_i);
		live_in <= 32'h0F0F_0003;
		rchk("image tracks", REG_IN_IMG, 32'h0F0F_0003);
		// 2 us limit: tick phase restarts on each exchange, so expiry comes about 250 cycles on
		wr(REG_WD_LIMIT, 32'h2);
		dxchk(7'h05, 32'hD4D4_0004, 1'b1);
		repeat (100) @(posedge clk_i);
		schk("failsafe early", ST_FAILSAFE, 1'b0);
		repeat (400) @(posedge clk_i);
		schk("failsafe", ST_FAILSAFE, 1'b1);
		chk("phys safe", 32'h0, phys_out);
		// the exchange that ends fail-safe drives the outputs itself
		m.dx(7'h05, 32'hD5D5_0005);
		schk("failsafe cleared", ST_FAILSAFE, 1'b0);
		chk("phys on recovery", 32'hD5D5_0005, phys_out);
		dxchk(7'h05, 32'hD6D6_0006, 1'b1);
		rchk("phys resumed", REG_PHYS, 32'hD6D6_0006);
		wrap_up;
	end
endmodule

`default_nettype wire
